// ### design/bprt_pkg.sv
// Package of constants, codes and carrier types for the brown-out and power-up sequencer.
package bprt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing. The system clock runs at 100 MHz.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int LF_PERIOD_NS    = 32000;
  localparam int LF_DIV_CYCLES   = LF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PUD_WIDTH       = 11;
  localparam int PUD_TICKS       = 2048;
  localparam int START_TICKS     = 1024;
  localparam int PLL_LOCK_NS     = 2000000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // The filter time is not fixed by the supply monitor; this is a plain default.
  localparam int FILTER_NS       = 1000;
  localparam int FILTER_CYCLES   = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Brown-out enable mode codes and flag reset values.
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_SOFT      = 2'h1;
  localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] MODE_ON        = 2'h3;
  localparam logic       FLAG_RST_VAL   = 1'h0;

  typedef enum logic [2:0] {
    ST_POR  = 3'h0,
    ST_BOR  = 3'h1,
    ST_PUD  = 3'h2,
    ST_XTAL = 3'h3,
    ST_PLL  = 3'h4,
    ST_RUN  = 3'h5
  } bprt_state_e;

  typedef struct packed {
    logic [1:0] brownout_enable_mode;
    logic [1:0] brownout_threshold_select;
    logic       powerup_delay_enable_n;
    logic       osc_startup_en;
    logic       pll_en;
  } bprt_cfg_s;

  typedef struct packed {
    logic por_flag_n;
    logic bor_flag_n;
    logic soft_brownout_enable;
    logic reference_stable_flag;
    logic brownout_armed;
  } bprt_status_s;

endpackage : bprt_pkg

// ### design/bprt_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module bprt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bprt_sync_s;

  bprt_sync_s r_q;
  bprt_sync_s r_d;

  // The first stage feeds only the second stage.
  always_comb begin
    r_d.meta   = async_in;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_out = r_q.stable;

endmodule : bprt_sync

// ### design/bprt_sequencer.sv
// Brown-out reset control and power-up reset timer sequencer.
//
// Summary of operation
// - Filtered supply drop resets when protection active.
// - Brown-out reset holds while supply stays low.
// - Power-up timer adds one delay after recovery.
// - Drop during power-up delay restarts whole delay.
// - Brown-out and power-up delay enable independently.
// - Low supply also keeps power-on reset held when protection armed.
// - Brown-out flag cleared on brown-out, and on power-on unless mode 00.
// - Mode 01: software bit enables or disables.
// - Software bit ignored, reads zero otherwise.
// - Threshold set only by configuration field.
// - Mode 10: protection off during sleep only.
// - Mode 11: protection always on.
// - Mode 00: protection always off.
// - Enabling requests reference unless another user demands it; detect after stable.
// - Unstable reference detects nothing; stable flag readable.
// - Power-up delay: 11-bit, 2048 slow ticks.
// - Reset held while power-up timer counts.
// - Active-low enable bit enables power-up timer.
// - Power-up, start-up, lock timers gate release.
// - Start-up timer counts 1024 oscillator cycles.
// - PLL lock wait of 2 ms follows.
// - Power-on flag cleared only by power-on.
`timescale 1ns/100ps
module bprt_sequencer #(
  parameter int LF_DIVIDE    = bprt_pkg::LF_DIV_CYCLES,
  parameter int PUD_COUNT    = bprt_pkg::PUD_TICKS,
  parameter int START_COUNT  = bprt_pkg::START_TICKS,
  parameter int PLL_CYCLES   = bprt_pkg::PLL_LOCK_CYCLES,
  parameter int FILTER_COUNT = bprt_pkg::FILTER_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   por_pulse,
  input  wire logic                   supply_low,
  input  wire logic                   reference_stable_in,
  input  wire logic                   other_ref_user,
  input  wire logic                   sleep_active,
  input  wire logic                   osc_cycle_tick,
  input  wire bprt_pkg::bprt_cfg_s    cfg,
  input  wire logic                   soft_brownout_enable_we,
  input  wire logic                   soft_brownout_enable_wdata,
  input  wire logic                   por_flag_set,
  input  wire logic                   bor_flag_set,
  output logic                        device_reset_hold,
  output logic                        fixed_voltage_ref_request,
  output logic [1:0]                  brownout_threshold_voltage_sel,
  output bprt_pkg::bprt_status_s      status
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks.
  localparam int LFW = $clog2(LF_DIVIDE + 1);
  localparam int FW  = $clog2(FILTER_COUNT + 1);
  localparam int TW  = $clog2(((PLL_CYCLES > START_COUNT) ? PLL_CYCLES : START_COUNT) + 1);

  if (PUD_COUNT < 1 || PUD_COUNT > (1 << bprt_pkg::PUD_WIDTH)) begin : g_pud_chk
    $error("Power-up count does not fit the 11-bit counter.");
  end
  if (LF_DIVIDE < 1 || START_COUNT < 1 || PLL_CYCLES < 1 || FILTER_COUNT < 1) begin : g_cnt_chk
    $error("Divider and timer counts must be at least one.");
  end

  typedef struct packed {
    bprt_pkg::bprt_state_e             st;
    logic [LFW-1:0]                    lf_cnt;
    logic [FW-1:0]                     filt;
    logic [bprt_pkg::PUD_WIDTH-1:0]    pud;
    logic [TW-1:0]                     tmr;
    logic                              por_n;
    logic                              bor_n;
    logic                              soft_en;
    logic [1:0]                        thr;
  } bprt_regs_s;

  bprt_regs_s r_q;
  bprt_regs_s r_d;
  logic [2:0] sync_s;
  logic       por_s;
  logic       low_s;
  logic       ref_s;
  logic       bor_en;
  logic       armed;
  logic       trip;
  logic       lf_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.
  bprt_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({por_pulse, supply_low, reference_stable_in}),
    .sync_out (sync_s)
  );

  assign por_s = sync_s[2];
  assign low_s = sync_s[1];
  assign ref_s = sync_s[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic mode_enable(input logic [1:0] mode, input logic soft_en,
                                       input logic sleep);
    logic en;
    en = 1'b0;
    if (mode == bprt_pkg::MODE_SOFT) begin
      en = soft_en;
    end else if (mode == bprt_pkg::MODE_SLEEP_OFF) begin
      en = !sleep;
    end else if (mode == bprt_pkg::MODE_ON) begin
      en = 1'b1;
    end
    return en;
  endfunction : mode_enable

  // The delay chain after a reset; each stage is skipped when it is not enabled.
  function automatic bprt_pkg::bprt_state_e after_pud(input bprt_pkg::bprt_cfg_s c);
    bprt_pkg::bprt_state_e s;
    s = bprt_pkg::ST_RUN;
    if (c.osc_startup_en) begin
      s = bprt_pkg::ST_XTAL;
    end else if (c.pll_en) begin
      s = bprt_pkg::ST_PLL;
    end
    return s;
  endfunction : after_pud

  function automatic bprt_pkg::bprt_state_e release_start(input bprt_pkg::bprt_cfg_s c);
    bprt_pkg::bprt_state_e s;
    s = after_pud(c);
    if (!c.powerup_delay_enable_n) begin
      s = bprt_pkg::ST_PUD;
    end
    return s;
  endfunction : release_start

  ////////////////////////////////////////////////////////////////////////////////
  // Protection enable, reference request and filter.
  assign bor_en  = mode_enable(cfg.brownout_enable_mode, r_q.soft_en, sleep_active);
  // Dropping the enable before the reference settles leaves nothing armed.
  assign armed   = bor_en && ref_s;
  assign trip    = armed && low_s && (r_q.filt == FW'(FILTER_COUNT - 1));
  assign lf_tick = (r_q.lf_cnt == LFW'(LF_DIVIDE - 1));

  always_comb begin
    r_d        = r_q;
    r_d.thr    = cfg.brownout_threshold_select;
    r_d.lf_cnt = lf_tick ? '0 : r_q.lf_cnt + 1'b1;
    if (armed && low_s) begin
      r_d.filt = (r_q.filt == FW'(FILTER_COUNT - 1)) ? r_q.filt : r_q.filt + 1'b1;
    end else begin
      r_d.filt = '0;
    end
    if (soft_brownout_enable_we && cfg.brownout_enable_mode == bprt_pkg::MODE_SOFT) begin
      r_d.soft_en = soft_brownout_enable_wdata;
    end
    // Software may only set the flags; a hardware clear in the same cycle wins.
    if (por_flag_set) begin
      r_d.por_n = 1'b1;
    end
    if (bor_flag_set) begin
      r_d.bor_n = 1'b1;
    end
    case (r_q.st)
      bprt_pkg::ST_POR: begin
        r_d.pud  = '0;
        r_d.tmr  = '0;
        if (!(low_s && armed)) begin
          r_d.st = release_start(cfg);
        end
      end
      bprt_pkg::ST_BOR: begin
        r_d.pud  = '0;
        r_d.tmr  = '0;
        if (!low_s) begin
          r_d.st = release_start(cfg);
        end
      end
      bprt_pkg::ST_PUD: begin
        if (lf_tick) begin
          r_d.pud = r_q.pud + 1'b1;
          if (r_q.pud == bprt_pkg::PUD_WIDTH'(PUD_COUNT - 1)) begin
            r_d.st = after_pud(cfg);
          end
        end
      end
      bprt_pkg::ST_XTAL: begin
        if (osc_cycle_tick) begin
          r_d.tmr = r_q.tmr + 1'b1;
          if (r_q.tmr == TW'(START_COUNT - 1)) begin
            r_d.tmr = '0;
            r_d.st  = cfg.pll_en ? bprt_pkg::ST_PLL : bprt_pkg::ST_RUN;
          end
        end
      end
      bprt_pkg::ST_PLL: begin
        r_d.tmr = r_q.tmr + 1'b1;
        if (r_q.tmr == TW'(PLL_CYCLES - 1)) begin
          r_d.st = bprt_pkg::ST_RUN;
        end
      end
      bprt_pkg::ST_RUN: begin
        r_d.tmr = '0;
      end
      default: begin
        r_d.st = bprt_pkg::ST_POR;
      end
    endcase
    if (por_s) begin
      r_d.st     = bprt_pkg::ST_POR;
      r_d.por_n  = 1'b0;
      r_d.soft_en = (cfg.brownout_enable_mode == bprt_pkg::MODE_SOFT);
      if (cfg.brownout_enable_mode != bprt_pkg::MODE_OFF) begin
        r_d.bor_n = 1'b0;
      end
    end else if (trip) begin
      r_d.st    = bprt_pkg::ST_BOR;
      r_d.pud   = '0;
      r_d.tmr   = '0;
      r_d.bor_n = 1'b0;
      if (cfg.brownout_enable_mode != bprt_pkg::MODE_SOFT) begin
        r_d.soft_en = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q        <= '0;
      r_q.st     <= bprt_pkg::ST_POR;
      r_q.por_n  <= bprt_pkg::FLAG_RST_VAL;
      r_q.bor_n  <= bprt_pkg::FLAG_RST_VAL;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign device_reset_hold              = (r_q.st != bprt_pkg::ST_RUN);
  assign fixed_voltage_ref_request      = bor_en && !other_ref_user;
  assign brownout_threshold_voltage_sel = r_q.thr;
  assign status.por_flag_n              = r_q.por_n;
  assign status.bor_flag_n              = r_q.bor_n;
  assign status.soft_brownout_enable    = r_q.soft_en &&
                                          (cfg.brownout_enable_mode == bprt_pkg::MODE_SOFT);
  assign status.reference_stable_flag   = ref_s;
  assign status.brownout_armed          = armed;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_trip_enters_bor: assert property (trip && !por_s |=> r_q.st == bprt_pkg::ST_BOR)
    else $error("Filtered supply drop did not enter brown-out reset.");
  a_bor_stays_low: assert property (
    r_q.st == bprt_pkg::ST_BOR && low_s && !por_s
    |=> r_q.st == bprt_pkg::ST_BOR && device_reset_hold)
    else $error("Brown-out reset released while supply low.");
  a_pud_follows_bor: assert property (
    r_q.st == bprt_pkg::ST_BOR && !low_s && !por_s && !cfg.powerup_delay_enable_n
    |=> r_q.st == bprt_pkg::ST_PUD)
    else $error("Power-up delay did not start after recovery.");
  a_pud_restart: assert property (
    r_q.st == bprt_pkg::ST_PUD && trip && !por_s
    |=> r_q.st == bprt_pkg::ST_BOR ##1 r_q.pud == '0)
    else $error("Power-up delay not restarted after supply drop.");
  a_bor_flag_clear: assert property (trip |=> !r_q.bor_n)
    else $error("Brown-out flag not cleared on brown-out reset.");
  a_por_flag_clear: assert property (por_s |=> !r_q.por_n)
    else $error("Power-on flag not cleared on power-on reset.");
  a_soft_reads_zero: assert property (
    cfg.brownout_enable_mode != bprt_pkg::MODE_SOFT |-> !status.soft_brownout_enable)
    else $error("Software enable read back set outside software mode.");
  a_no_unstable_trip: assert property (
    !ref_s || cfg.brownout_enable_mode == bprt_pkg::MODE_OFF |-> !trip)
    else $error("Brown-out detected without armed protection.");
  a_sleep_disables: assert property (
    cfg.brownout_enable_mode == bprt_pkg::MODE_SLEEP_OFF && sleep_active
    |-> !armed && !fixed_voltage_ref_request)
    else $error("Protection active during sleep.");
  a_pud_length: assert property (
    r_q.st == bprt_pkg::ST_PUD && lf_tick && !trip && !por_s &&
    r_q.pud == bprt_pkg::PUD_WIDTH'(PUD_COUNT - 1)
    |=> r_q.st != bprt_pkg::ST_PUD)
    else $error("Power-up delay did not end after full count.");
  a_trip_needs_filter: assert property (trip |-> $past(armed && low_s))
    else $error("Brown-out detected without a filtered drop.");

  c_brownout_trip: cover property (trip);
  c_release_run: cover property (r_q.st == bprt_pkg::ST_PUD ##1 r_q.st == bprt_pkg::ST_RUN);
  c_pud_abort: cover property (r_q.st == bprt_pkg::ST_PUD ##1 r_q.st == bprt_pkg::ST_BOR);

endmodule : bprt_sequencer

// ### verif/bprt_analog_model.sv
// Behavioural model of the supply monitor, fixed voltage reference and power-on pulse source.
`timescale 1ns/100ps
module bprt_analog_model #(
  parameter int SETTLE = 20
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ref_request,
  input  wire logic other_ref_user,
  input  wire logic vdd_low_cmd,
  input  wire logic por_cmd,
  output logic      supply_low,
  output logic      reference_stable_in,
  output logic      por_pulse
);
  int settle_q;
  ////////////////////////////////////////////////////////////////////////////////
  // The reference needs SETTLE cycles of demand and loses stability at once when dropped,
  // so a quick enable and disable never sees a usable reference.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_q <= 0;
    end else if (ref_request === 1'b1 || other_ref_user) begin
      settle_q <= (settle_q < SETTLE) ? settle_q + 1 : SETTLE;
    end else begin
      settle_q <= 0;
    end
  end
  assign reference_stable_in = (settle_q == SETTLE);
  assign supply_low          = vdd_low_cmd;
  assign por_pulse           = por_cmd;
endmodule : bprt_analog_model

// ### verif/test_bprt_sequencer.sv
// Self-checking testbench of the brown-out and power-up sequencer.
`timescale 1ns/100ps
module test_bprt_sequencer;
  typedef struct {int kind; logic [4:0] exp; logic [4:0] mask;} bprt_note_s;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  por_cmd = 1'b1;
  logic                  vdd_low = 1'b0;
  logic                  other_ref_user = 1'b0;
  logic                  sleep_active = 1'b0;
  logic                  osc_cycle_tick = 1'b0;
  logic                  sb_we = 1'b0;
  logic                  sb_wdata = 1'b0;
  logic                  por_flag_set = 1'b0;
  logic                  bor_flag_set = 1'b0;
  bprt_pkg::bprt_cfg_s   cfg = '{bprt_pkg::MODE_ON, 2'h0, 1'b0, 1'b0, 1'b0};
  logic                  por_pulse, supply_low, ref_stable, device_reset_hold, ref_req;
  logic [1:0]            thr_sel;
  bprt_pkg::bprt_status_s status;
  logic [1:0]            modes [3] = '{bprt_pkg::MODE_OFF, bprt_pkg::MODE_SLEEP_OFF,
                                       bprt_pkg::MODE_SOFT};
  bprt_note_s            exp_q [$];
  bprt_note_s            cur;
  int                    failures = 0;
  int                    total_checks = 0;

  always #5 clk = ~clk;
  always @(posedge clk) osc_cycle_tick <= 1'($urandom % 2);

  bprt_analog_model ana (.clk(clk), .sys_rst(sys_rst), .ref_request(ref_req),
    .other_ref_user(other_ref_user), .vdd_low_cmd(vdd_low), .por_cmd(por_cmd),
    .supply_low(supply_low), .reference_stable_in(ref_stable), .por_pulse(por_pulse));

  // Short counts keep the run brief; every bound below is derived from these.
  bprt_sequencer #(.LF_DIVIDE(4), .PUD_COUNT(8), .START_COUNT(4), .PLL_CYCLES(10),
    .FILTER_COUNT(3)) uut (.clk(clk), .sys_rst(sys_rst), .por_pulse(por_pulse),
    .supply_low(supply_low), .reference_stable_in(ref_stable),
    .other_ref_user(other_ref_user), .sleep_active(sleep_active),
    .osc_cycle_tick(osc_cycle_tick), .cfg(cfg), .soft_brownout_enable_we(sb_we),
    .soft_brownout_enable_wdata(sb_wdata), .por_flag_set(por_flag_set),
    .bor_flag_set(bor_flag_set), .device_reset_hold(device_reset_hold),
    .fixed_voltage_ref_request(ref_req), .brownout_threshold_voltage_sel(thr_sel),
    .status(status));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic note(input int kind, input logic [4:0] exp, input logic [4:0] mask);
    bprt_note_s n;
    @(negedge clk);
    n.kind = kind;
    n.exp = exp;
    n.mask = mask;
    exp_q.push_back(n);
  endtask : note

  task automatic wait_rel(input int max);
    for (int i = 0; i < max && device_reset_hold !== 1'b0; i++) @(negedge clk);
    note(0, 5'h00, 5'h01);
  endtask : wait_rel

  task automatic drop(input int n);
    cyc(1);
    vdd_low <= 1'b1;
    cyc(n);
    vdd_low <= 1'b0;
  endtask : drop

  task automatic soft_write(input logic v);
    cyc(1);
    sb_we <= 1'b1;
    sb_wdata <= v;
    cyc(1);
    sb_we <= 1'b0;
  endtask : soft_write

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  task automatic cmp_status(input logic [4:0] exp, input logic [4:0] mask);
    total_checks++;
    if ((5'(status) & mask) !== (exp & mask)) begin
      failures++;
      $display("BAD status expected %h seen %h", exp & mask, 5'(status) & mask);
    end
  endtask : cmp_status

  task automatic cmp_sel(input logic [1:0] exp);
    total_checks++;
    if (thr_sel !== exp) begin
      failures++;
      $display("BAD threshold expected %h seen %h", exp, thr_sel);
    end
  endtask : cmp_sel

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  always begin
    wait (exp_q.size() != 0);
    cur = exp_q.pop_front();
    case (cur.kind)
      0: cmp_bit("hold", cur.exp[0], device_reset_hold);
      1: cmp_status(cur.exp, cur.mask);
      2: cmp_bit("request", cur.exp[0], ref_req);
      default: cmp_sel(cur.exp[1:0]);
    endcase
  end

  initial begin
    #50000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [1:0] t;
    void'($urandom(32'hc8e782e6));
    cyc(5);
    sys_rst <= 1'b0;
    cyc(3);
    note(1, 5'h00, 5'h18);
    cyc(1);
    por_cmd <= 1'b0;
    cyc(20);
    note(0, 5'h01, 5'h01);
    note(2, 5'h01, 5'h01);
    wait_rel(60);
    cyc(1);
    por_flag_set <= 1'b1;
    bor_flag_set <= 1'b1;
    cyc(1);
    por_flag_set <= 1'b0;
    bor_flag_set <= 1'b0;
    note(1, 5'h18, 5'h18);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      t = 2'($urandom % 4);
      cfg.brownout_threshold_select <= t;
      soft_write(1'b1);
      note(3, {3'h0, t}, 5'h03);
    end
    note(1, 5'h00, 5'h04);
    cyc(1);
    vdd_low <= 1'b1;
    cyc(10);
    note(0, 5'h01, 5'h01);
    note(1, 5'h10, 5'h18);
    cyc(30);
    note(0, 5'h01, 5'h01);
    cyc(1);
    vdd_low <= 1'b0;
    cyc(15);
    drop(10);
    cyc(25);
    note(0, 5'h01, 5'h01);
    wait_rel(60);
    drop(1);
    cyc(10);
    note(0, 5'h00, 5'h01);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      cfg.brownout_enable_mode <= modes[i];
      sleep_active <= (i == 1);
      soft_write(1'b0);
      cyc(25);
      drop(15);
      note(0, 5'h00, 5'h01);
    end
    soft_write(1'b1);
    note(1, 5'h04, 5'h04);
    cyc(25);
    drop(15);
    note(0, 5'h01, 5'h01);
    wait_rel(60);
    cyc(1);
    cfg.brownout_enable_mode <= bprt_pkg::MODE_SLEEP_OFF;
    sleep_active <= 1'b0;
    cyc(25);
    drop(15);
    note(0, 5'h01, 5'h01);
    wait_rel(60);
    cyc(1);
    sleep_active <= 1'b1;
    cyc(5);
    note(1, 5'h00, 5'h02);
    note(2, 5'h00, 5'h01);
    cyc(1);
    sleep_active <= 1'b0;
    drop(8);
    note(0, 5'h00, 5'h01);
    cyc(25);
    note(1, 5'h03, 5'h03);
    cyc(1);
    other_ref_user <= 1'b1;
    note(2, 5'h00, 5'h01);
    cyc(1);
    other_ref_user <= 1'b0;
    cfg <= '{bprt_pkg::MODE_ON, t, 1'b1, 1'b1, 1'b1};
    cyc(25);
    drop(15);
    cyc(6);
    note(0, 5'h01, 5'h01);
    wait_rel(150);
    cyc(1);
    cfg.osc_startup_en <= 1'b0;
    cfg.pll_en <= 1'b0;
    drop(15);
    wait_rel(12);
    cyc(1);
    cfg.powerup_delay_enable_n <= 1'b0;
    por_cmd <= 1'b1;
    vdd_low <= 1'b1;
    cyc(4);
    por_cmd <= 1'b0;
    cyc(20);
    note(0, 5'h01, 5'h01);
    note(1, 5'h00, 5'h18);
    cyc(1);
    vdd_low <= 1'b0;
    wait_rel(60);
    cyc(2);
    end_of_test();
  end
endmodule : test_bprt_sequencer
